// ==== design/dacbl_host.sv ====
/*
  host-side controller that drives the pins of a double-buffered
  12-bit converter latch: sets up enables and data, strobes the
  write gate, then holds data past the strobe.
  assumes the user side is on i_clk; converter pins are outputs only.
*/
`timescale 1ns/1ps
module dacbl_host
  import dacbl_pkg::*;
#(
  parameter int SETUP_CYCLES  = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES   = HOLD_CYC
)
(
  // clock and control
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // user command port
  input  wire logic              i_req,
  input  wire logic [2:0]        i_cmd,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_twos,
  output logic                   o_busy,
  output logic                   o_done,
  // converter pins
  output logic                   o_write_gate_n,
  output logic                   o_low_byte_enable_n,
  output logic                   o_high_nibble_enable_n,
  output logic                   o_output_latch_load_n,
  output logic                   o_reset_n,
  output logic [DATA_W-1:0]      o_data_in_bits
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  dacbl_state_t      state_r,  state_nxt;
  logic [CNT_W-1:0]  cnt_r,    cnt_nxt;
  logic [2:0]        cmd_r,    cmd_nxt;
  logic [11:0]       data_r,   data_nxt;
  logic              twos_r,   twos_nxt;
  logic              wr_n_r,   wr_n_nxt;
  logic              busy_r,   busy_nxt;
  logic              done_r,   done_nxt;
  logic              le_n_r,   le_n_nxt;
  logic              he_n_r,   he_n_nxt;
  logic              ld_n_r,   ld_n_nxt;
  logic              rs_n_r,   rs_n_nxt;
  logic [11:0]       pins_r,   pins_nxt;
  logic              map_le_n;
  logic              map_he_n;
  logic              map_ld_n;
  logic              map_rs_n;
  logic [11:0]       map_data;

  // --------------------------------------------------------------
  // pin decode
  // --------------------------------------------------------------
  dacbl_pinmap u_pinmap (
    .i_cmd                  (cmd_r),
    .i_data                 (data_r),
    .i_twos                 (twos_r),
    .o_low_byte_enable_n    (map_le_n),
    .o_high_nibble_enable_n (map_he_n),
    .o_output_latch_load_n  (map_ld_n),
    .o_reset_n              (map_rs_n),
    .o_data_in_bits         (map_data)
  );

  // --------------------------------------------------------------
  // sequencer next state
  // --------------------------------------------------------------
  // setup, strobe, hold; gate only drops once enables settled
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cmd_nxt   = cmd_r;
    data_nxt  = data_r;
    twos_nxt  = twos_r;
    wr_n_nxt  = wr_n_r;
    busy_nxt  = busy_r;
    done_nxt  = 1'b0;
    le_n_nxt  = le_n_r;
    he_n_nxt  = he_n_r;
    ld_n_nxt  = ld_n_r;
    rs_n_nxt  = 1'b1;
    pins_nxt  = pins_r;
    case (state_r)
      DACBL_IDLE:
      begin
        wr_n_nxt = 1'b1;
        if (i_req)
        begin
          cmd_nxt   = i_cmd;
          data_nxt  = i_data;
          twos_nxt  = i_twos;
          busy_nxt  = 1'b1;
          cnt_nxt   = CNT_W'(SETUP_CYCLES - 1);
          state_nxt = DACBL_SETUP;
        end
      end
      DACBL_SETUP:
      begin
        // unused bits stay driven, never left floating
        le_n_nxt = map_le_n;
        he_n_nxt = map_he_n;
        ld_n_nxt = map_ld_n;
        rs_n_nxt = map_rs_n;
        pins_nxt = map_data;
        if (cnt_r == '0)
        begin
          cnt_nxt   = CNT_W'(STROBE_CYCLES - 1);
          state_nxt = DACBL_STROBE;
          // gate drops only when some latch enable is low
          wr_n_nxt  = map_le_n & map_he_n & map_ld_n;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      DACBL_STROBE:
      begin
        rs_n_nxt = map_rs_n;
        if (cnt_r == '0)
        begin
          wr_n_nxt  = 1'b1;                 // rising gate captures
          cnt_nxt   = CNT_W'(HOLD_CYCLES - 1);
          state_nxt = DACBL_HOLD;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      DACBL_HOLD:
      begin
        if (cnt_r == '0)
        begin
          le_n_nxt  = 1'b1;
          he_n_nxt  = 1'b1;
          ld_n_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = DACBL_IDLE;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
      begin
        state_nxt = DACBL_IDLE;
        wr_n_nxt  = 1'b1;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // clock enable freezes everything; reset parks pins inactive
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_r <= DACBL_IDLE;
      cnt_r   <= '0;
      cmd_r   <= CMD_LOW;
      data_r  <= MID_CODE;
      twos_r  <= 1'b0;
      wr_n_r  <= 1'b1;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      le_n_r  <= 1'b1;
      he_n_r  <= 1'b1;
      ld_n_r  <= 1'b1;
      rs_n_r  <= 1'b1;
      pins_r  <= 12'h000;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cmd_r   <= cmd_nxt;
      data_r  <= data_nxt;
      twos_r  <= twos_nxt;
      wr_n_r  <= wr_n_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
      le_n_r  <= le_n_nxt;
      he_n_r  <= he_n_nxt;
      ld_n_r  <= ld_n_nxt;
      rs_n_r  <= rs_n_nxt;
      pins_r  <= pins_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign o_busy                 = busy_r;
  assign o_done                 = done_r;
  assign o_write_gate_n         = wr_n_r;
  assign o_low_byte_enable_n    = le_n_r;
  assign o_high_nibble_enable_n = he_n_r;
  assign o_output_latch_load_n  = ld_n_r;
  assign o_reset_n              = rs_n_r;
  assign o_data_in_bits         = pins_r;

endmodule : dacbl_host

// ==== design/dacbl_pinmap.sv ====
/*
  maps a command code and data word to the pin levels of the
  converter's input latch controls and data bits.
  assumes the caller registers the outputs before they reach pins.
*/
`timescale 1ns/1ps
module dacbl_pinmap
  import dacbl_pkg::*;
(
  // command
  input  wire logic [2:0]  i_cmd,
  input  wire logic [11:0] i_data,
  input  wire logic        i_twos,
  // pin levels
  output logic             o_low_byte_enable_n,
  output logic             o_high_nibble_enable_n,
  output logic             o_output_latch_load_n,
  output logic             o_reset_n,
  output logic [11:0]      o_data_in_bits
);

  // --------------------------------------------------------------
  // enable decoding
  // --------------------------------------------------------------
  // enables of the selected latches go low; others stay high so they keep their data
  always_comb
  begin
    o_low_byte_enable_n    = 1'b1;
    o_high_nibble_enable_n = 1'b1;
    o_output_latch_load_n  = 1'b1;
    o_reset_n              = 1'b1;
    case (i_cmd)
      CMD_LOW:     o_low_byte_enable_n = 1'b0;
      CMD_HIGH:    o_high_nibble_enable_n = 1'b0;
      CMD_LOAD:    o_output_latch_load_n = 1'b0;
      CMD_HIGH_LD:
      begin
        o_high_nibble_enable_n = 1'b0;
        o_output_latch_load_n  = 1'b0;
      end
      CMD_FULL:
      begin
        o_low_byte_enable_n    = 1'b0;
        o_high_nibble_enable_n = 1'b0;
        o_output_latch_load_n  = 1'b0;
      end
      CMD_RESET:   o_reset_n = 1'b0;
      default:     o_reset_n = 1'b1;
    endcase
  end

  // two's complement needs the top bit turned round
  always_comb
  begin
    o_data_in_bits          = i_data;
    o_data_in_bits[MSB_POS] = i_data[MSB_POS] ^ i_twos;
  end

endmodule : dacbl_pinmap

// ==== design/dacbl_pkg.sv ====
/*
  constants shared by the host-side controller of a double-buffered
  12-bit converter input latch.
  assumes a 125 MHz clock; pin timing in ns is turned into cycles here.
*/
package dacbl_pkg;

  // ----------------------------------------------------------------
  // data word layout
  // ----------------------------------------------------------------
  localparam int          DATA_W      = 12;
  localparam int          LOW_LSB     = 0;
  localparam int          LOW_W       = 8;
  localparam int          HIGH_LSB    = 8;
  localparam int          HIGH_W      = 4;
  localparam int          MSB_POS     = 11;
  localparam logic [11:0] MID_CODE    = 12'h800;

  // ----------------------------------------------------------------
  // command codes on the user side
  // ----------------------------------------------------------------
  localparam logic [2:0]  CMD_LOW     = 3'h0; // low byte only
  localparam logic [2:0]  CMD_HIGH    = 3'h1; // high nibble only
  localparam logic [2:0]  CMD_LOAD    = 3'h2; // transfer to output latch
  localparam logic [2:0]  CMD_HIGH_LD = 3'h3; // high nibble plus transfer
  localparam logic [2:0]  CMD_FULL    = 3'h4; // all latches transparent
  localparam logic [2:0]  CMD_RESET   = 3'h5; // force mid code

  // ----------------------------------------------------------------
  // timing, own unit then cycles
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETUP_NS      = 40; // enables and data before strobe
  localparam int STROBE_NS     = 40; // write gate low time
  localparam int HOLD_NS       = 16; // data held after strobe rises
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 4;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DACBL_IDLE   = 3'b000,
    DACBL_SETUP  = 3'b001,
    DACBL_STROBE = 3'b010,
    DACBL_HOLD   = 3'b011
  } dacbl_state_t;

endpackage : dacbl_pkg

// ==== test/dacbl_dev.sv ====
/*
  behavioural model of the converter's double-buffered input latches.
  assumes pins come straight from the host controller.
*/
`timescale 1ns/1ps
module dacbl_dev
(
  // control and data pins
  input  wire logic  i_wr_n,
  input  wire logic  i_lo_n,
  input  wire logic  i_hi_n,
  input  wire logic  i_ld_n,
  input  wire logic  i_rst_n,
  input  wire logic  [11:0] i_d,
  // converter latch contents
  output logic [11:0] o_code
);
  logic [7:0] lo_q;
  logic [3:0] hi_q;
  // input latches, level sensitive, own enable per latch
  always_latch
    if (!i_wr_n && !i_lo_n) lo_q <= i_d[7:0];
  always_latch
    if (!i_wr_n && !i_hi_n) hi_q <= i_d[11:8];
  // converter latch, loads only the assembled word
  always_latch
    if (!i_rst_n) o_code <= 12'h800;
    else if (!i_wr_n && !i_ld_n)
      o_code <= {hi_q, lo_q};
endmodule : dacbl_dev

// ==== test/dacbl_host_asserts.sv ====
/*
  pin-order checks on the host controller of the converter latch.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dacbl_chk
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // watched pins
  input wire logic        o_done,
  input wire logic        o_write_gate_n,
  input wire logic        o_low_byte_enable_n,
  input wire logic        o_high_nibble_enable_n,
  input wire logic        o_output_latch_load_n,
  input wire logic        o_reset_n,
  input wire logic [11:0] o_data_in_bits
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_gate_needs_select: assert property (!o_write_gate_n |->
    !(o_low_byte_enable_n && o_high_nibble_enable_n
      && o_output_latch_load_n)) else $error("gate low, no select");
  a_setup_before_gate: assert property ($fell(o_write_gate_n) |->
    $stable({o_low_byte_enable_n, o_high_nibble_enable_n,
      o_output_latch_load_n, o_data_in_bits})) else $error("no setup");
  a_hold_after_gate: assert property ($rose(o_write_gate_n) |->
    $stable(o_data_in_bits) ##1 $stable(o_data_in_bits))
    else $error("data hold too short");
  a_reset_pulse_end: assert property ($fell(o_reset_n) |->
    ##[1:12] o_reset_n) else $error("reset left asserted");
  a_data_kept_driven: assert property (o_done |=>
    $stable(o_data_in_bits)) else $error("data pins changed at end");
  // main scenarios
  c_strobe: cover property ($fell(o_write_gate_n));
  c_reset: cover property ($fell(o_reset_n));
  c_load: cover property (!o_write_gate_n && !o_output_latch_load_n);
endmodule : dacbl_chk
bind dacbl_host dacbl_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .o_done(o_done), .o_write_gate_n(o_write_gate_n),
  .o_low_byte_enable_n(o_low_byte_enable_n),
  .o_high_nibble_enable_n(o_high_nibble_enable_n),
  .o_output_latch_load_n(o_output_latch_load_n),
  .o_reset_n(o_reset_n), .o_data_in_bits(o_data_in_bits));

// ==== test/tb_top.sv ====
/*
  testbench for the host controller driving a converter latch model.
  assumes the default setup, strobe and hold counts of the package.
*/
`timescale 1ns/1ps
module tb_top;
  import dacbl_pkg::*;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_req = 0, i_twos = 0;
  logic [2:0] i_cmd = 3'h0;
  logic [11:0] i_data = 12'h000, dbits, code;
  logic busy, done, wr_n, lo_n, hi_n, ld_n, rs_n;
  int num_errors = 0, checks_done = 0;
  int gate_cnt = 0;
  always #4 i_clk = ~i_clk;
  // counts every write gate strobe seen at the pin
  always @(negedge wr_n) gate_cnt++;
  dacbl_host DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_req(i_req), .i_cmd(i_cmd), .i_data(i_data), .i_twos(i_twos),
    .o_busy(busy), .o_done(done), .o_write_gate_n(wr_n),
    .o_low_byte_enable_n(lo_n), .o_high_nibble_enable_n(hi_n),
    .o_output_latch_load_n(ld_n), .o_reset_n(rs_n),
    .o_data_in_bits(dbits));
  dacbl_dev u_dev (.i_wr_n(wr_n), .i_lo_n(lo_n), .i_hi_n(hi_n),
    .i_ld_n(ld_n), .i_rst_n(rs_n), .i_d(dbits), .o_code(code));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // one command, waits for the done pulse
  task automatic run(input logic [2:0] c, input logic [11:0] d,
                     input logic t);
    int n;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_cmd <= c;
    i_data <= d;
    i_twos <= t;
    @(posedge i_clk);
    i_req <= 1'b0;
    #1 chk(12'h001, {11'h000, busy});
    for (n = 0; n < 40 && done !== 1'b1; n++)
      @(posedge i_clk) #1;
    if (n == 40)
    begin
      num_errors++;
      end_of_test;
    end
    chk(12'h000, {11'h000, busy});
  endtask : run
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    run(CMD_FULL, 12'hFFF, 1'b0);
    run(CMD_RESET, 12'h000, 1'b0);
    chk(12'h800, code);
    $display("test reset done");
  endtask : t_reset
  task automatic t_bytes;
    run(CMD_LOW, 12'hF5A, 1'b0);
    run(CMD_HIGH, 12'h3FF, 1'b0);
    chk(12'h800, code);
    run(CMD_LOAD, 12'h000, 1'b0);
    chk(12'h35A, code);
    $display("test bytes done");
  endtask : t_bytes
  task automatic t_pair;
    run(CMD_LOW, 12'h0A5, 1'b0);
    run(CMD_HIGH_LD, 12'hC00, 1'b0);
    chk(12'hCA5, code);
    $display("test pair done");
  endtask : t_pair
  task automatic t_full;
    int g0;
    g0 = gate_cnt;
    run(CMD_FULL, 12'h123, 1'b0);
    chk(12'h123, code);
    run(CMD_FULL, 12'h123, 1'b1);
    chk(12'h923, code);
    chk(12'h002, 12'(gate_cnt - g0));
    $display("test full done");
  endtask : t_full
  task automatic t_nop;
    int g0;
    g0 = gate_cnt;
    run(3'h6, 12'h456, 1'b0);
    chk(12'h923, code);
    chk(12'h000, 12'(gate_cnt - g0));
    $display("test nop done");
  endtask : t_nop
  // clock enable low holds a pending request off
  task automatic t_freeze;
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_req <= 1'b1;
    i_cmd <= CMD_FULL;
    i_data <= 12'h321;
    repeat (4) @(posedge i_clk);
    #1 chk(12'h000, {11'h000, busy});
    chk(12'h923, code);
    @(posedge i_clk);
    i_ce <= 1'b1;
    i_req <= 1'b0;
    run(CMD_FULL, 12'h321, 1'b0);
    chk(12'h321, code);
    $display("test freeze done");
  endtask : t_freeze
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_bytes;
    t_pair;
    t_full;
    t_nop;
    t_freeze;
    end_of_test;
  end
endmodule : tb_top
